/* File: hdl/mibec_pkg.sv */
// Purpose: Shared constants and types for the bridge event counter unit.
// Assumes: One uncore clock, AXI4-Lite register access with 32-bit data.
// Notes:   Event codes select what each counter adds every cycle.
`default_nettype none
package mibec_pkg;
	// Event codes.
	localparam logic [7:0] EVT_UNCORE_CYCLE = 8'h01;
	localparam logic [7:0] EVT_IN_NE        = 8'h10;
	localparam logic [7:0] EVT_IN_INS       = 8'h11;
	localparam logic [7:0] EVT_OCC          = 8'h14;
	localparam logic [7:0] EVT_SHR_RCV      = 8'h15;
	localparam logic [7:0] EVT_DED_RCV      = 8'h16;
	localparam logic [7:0] EVT_LSH_RET      = 8'h17;
	localparam logic [7:0] EVT_RSH_RET      = 8'h18;
	localparam logic [7:0] EVT_LDD_RET_A    = 8'h19;
	localparam logic [7:0] EVT_LDD_RET_B    = 8'h1a;
	localparam logic [7:0] EVT_RDD_RET      = 8'h1b;
	localparam logic [7:0] EVT_EG_NE        = 8'h23;
	localparam logic [7:0] EVT_EG_INS       = 8'h24;
	localparam logic [7:0] EVT_EG_FULL      = 8'h25;
	localparam logic [7:0] EVT_HELD         = 8'h32;
	localparam logic [7:0] EVT_OBT          = 8'h33;
	localparam logic [7:0] EVT_REF          = 8'h34;
	localparam logic [7:0] EVT_LSH_TK_A     = 8'h40;
	localparam logic [7:0] EVT_LSH_TK_B     = 8'h41;
	localparam logic [7:0] EVT_RSH_TK_A     = 8'h42;
	localparam logic [7:0] EVT_RSH_TK_B     = 8'h43;
	localparam logic [7:0] EVT_LSH_BACK     = 8'h44;
	localparam logic [7:0] EVT_RSH_BACK     = 8'h45;
	localparam logic [7:0] EVT_LDD_TK_A     = 8'h46;
	localparam logic [7:0] EVT_LDD_TK_B     = 8'h47;
	localparam logic [7:0] EVT_RDD_TK_A     = 8'h48;
	localparam logic [7:0] EVT_RDD_TK_B     = 8'h49;
	localparam logic [7:0] EVT_LSH_WAIT_A   = 8'h4a;
	localparam logic [7:0] EVT_LSH_WAIT_B   = 8'h4b;
	localparam logic [7:0] EVT_RSH_WAIT_A   = 8'h4c;
	localparam logic [7:0] EVT_RSH_WAIT_B   = 8'h4d;
	// Register byte offsets and field positions.
	localparam logic [7:0] OFS_GLOB      = 8'h00;
	localparam logic [7:0] OFS_CTL_BASE  = 8'h10;
	localparam logic [7:0] OFS_CTR_BASE  = 8'h20;
	localparam int         CTL_EVT_LSB   = 0;
	localparam int         CTL_MASK_LSB  = 8;
	localparam int         CTL_EN_BIT    = 22;
	localparam int         GLOB_EN_BIT   = 0;
	localparam int         GLOB_FRZ_BIT  = 1;
	localparam logic [31:0] CTL_RST      = 32'h0000_0000;
	localparam logic [1:0]  GLOB_RST     = 2'h0;
	// Unit-mask bits raised by the local credit check.
	localparam int OBT_BYPASS_BIT = 2;
	localparam int OBT_STD_BIT    = 4;
	localparam int REF_BYPASS_BIT = 4;
	localparam int REF_STD_BIT    = 5;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Per-cycle event indications from the bridge logic.
	typedef struct packed {
		logic       ingress_not_empty_cycles;
		logic       ingress_insertions;
		logic       egress_not_empty_cycles;
		logic       egress_insertions;
		logic       egress_full_cycles;
		logic [7:0] stack_credit_held_cycles;
		logic [7:0] stack_credit_obtained;
		logic [7:0] stack_credit_refused;
		logic [7:0] shared_credit_received;
		logic [7:0] dedicated_credit_received;
		logic [7:0] local_shared_peer_returned;
		logic [7:0] remote_shared_peer_returned;
		logic [7:0] local_dedicated_peer_returned_a;
		logic [7:0] local_dedicated_peer_returned_b;
		logic [7:0] remote_dedicated_peer_returned;
		logic [7:0] local_shared_peer_taken_a;
		logic [7:0] local_shared_peer_taken_b;
		logic [7:0] remote_shared_peer_taken_a;
		logic [7:0] remote_shared_peer_taken_b;
		logic [7:0] local_shared_peer_given_back;
		logic [7:0] remote_shared_peer_given_back;
		logic [7:0] local_dedicated_peer_taken_a;
		logic [7:0] local_dedicated_peer_taken_b;
		logic [7:0] remote_dedicated_peer_taken_a;
		logic [7:0] remote_dedicated_peer_taken_b;
		logic [7:0] local_shared_peer_wait_a;
		logic [7:0] local_shared_peer_wait_b;
		logic [7:0] remote_shared_peer_wait_a;
		logic [7:0] remote_shared_peer_wait_b;
		logic [6:0] peer_credit_occupancy;
	} mibec_event_s;
endpackage
`default_nettype wire

/* File: hdl/mibec_counters.sv */
// Purpose: Event counter unit of the mesh_io_bridge with AXI4-Lite access.
// Assumes: Event inputs come from logic on the same clock.
// Notes:   Counters read as two words; software must handle tearing.
// Overview of operation
// - Four 48-bit counters, each with control.
// - Up to five-bit increment every cycle.
// - Occupancy counts only on counter zero.
// - Code 01 counts every uncore cycle.
// - Codes 10/11: ingress busy cycles, insertions.
// - Code 23 egress busy, counters 0-1; 24 inserts.
// - Code 25 counts egress full cycles.
// - Forward to stack only with class credit.
// - Code 33 counts credits obtained, umask selected.
// - Code 34 counts refused credit attempts.
// - Code 32 counts cycles credits held.
// - Code 46 dedicated taken, up to three.
// - Code 47 dedicated taken, at most one.
// - Code 19 counts dedicated credits returned.
// - Codes 40-43 count shared credits taken.
// - Codes 44/45 shared credits given back.
// - Codes 4a/4b local shared credit waits.
// - Codes 4c/4d remote shared credit waits.
// - Codes 17/18 shared returned, up to three.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`default_nettype none
module mibec_counters
	import mibec_pkg::*;
#(
	parameter int NUM_CTR = 4,
	parameter int CTR_W   = 48
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire mibec_event_s bridge_events,
	input  wire logic         ring_req_valid,
	input  wire logic         ring_req_standard,
	input  wire logic [1:0]   stack_credit_free,
	output logic              stack_fwd_valid,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready
);
	// The address map and increment width are built for exactly this shape.
	// Any other shape is refused while the design is elaborated, so a wrong
	// parameter can never reach silicon as a unit with holes in its map.
	if (NUM_CTR != 4 || CTR_W != 48) begin : g_bad_shape
		$error("mibec_counters supports four 48-bit counters only");
	end

	logic [31:0]      ctl_reg [NUM_CTR];
	logic [CTR_W-1:0] ctr_reg [NUM_CTR];
	logic [1:0]       glob_reg;
	logic [4:0]       inc_w [NUM_CTR];
	logic             run_w;
	mibec_event_s     ev_w;
	logic             obtain_w;
	logic             refuse_w;
	logic             aw_hold_reg;
	logic             w_hold_reg;
	logic [7:0]       awaddr_reg;
	logic [31:0]      wdata_reg;
	logic [3:0]       wstrb_reg;
	logic             wr_fire;
	logic             wr_ok;
	logic [31:0]      wr_old;
	logic [31:0]      wr_word;
	logic             rd_ok;
	logic [31:0]      rd_word;
	logic             bvalid_reg;
	logic [1:0]       bresp_reg;
	logic             rvalid_reg;
	logic [31:0]      rdata_reg;
	logic [1:0]       rresp_reg;
	logic [NUM_CTR-1:0] ctr_lo_wr;
	logic [NUM_CTR-1:0] ctr_hi_wr;

	// Number of set bits in an eight-bit vector.
	function automatic logic [3:0] pop8(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int k = 0; k < 8; k++) begin
			n = n + {3'h0, v[k]};
		end
		return n;
	endfunction

	// Masked occurrence count, limited to the event's per-cycle maximum.
	function automatic logic [4:0] cap(input logic [7:0] v, input logic [7:0] m,
		input logic [4:0] mx);
		logic [3:0] n;
		n = pop8(v & m);
		return ({1'b0, n} > mx) ? mx : {1'b0, n};
	endfunction

	// Per-cycle amount for one counter from its code and unit mask.
	function automatic logic [4:0] sel_inc(input logic [7:0] c, input logic [7:0] m,
		input logic first, input logic low_pair, input mibec_event_s e);
		logic [4:0] r;
		r = 5'h00;
		case (c)
			EVT_UNCORE_CYCLE: r = 5'h01;
			EVT_IN_NE:      r = {4'h0, e.ingress_not_empty_cycles};
			EVT_IN_INS:     r = {4'h0, e.ingress_insertions};
			EVT_EG_NE:      r = {4'h0, e.egress_not_empty_cycles & low_pair};
			EVT_EG_INS:     r = {4'h0, e.egress_insertions};
			EVT_EG_FULL:    r = {4'h0, e.egress_full_cycles};
			EVT_HELD:       r = {4'h0, |(e.stack_credit_held_cycles & m)};
			EVT_OBT:        r = cap(e.stack_credit_obtained, m, 5'h01);
			EVT_REF:        r = cap(e.stack_credit_refused, m, 5'h01);
			EVT_SHR_RCV:    r = cap(e.shared_credit_received, m, 5'h01);
			EVT_DED_RCV:    r = cap(e.dedicated_credit_received, m, 5'h01);
			EVT_LSH_RET:    r = cap(e.local_shared_peer_returned, m, 5'h03);
			EVT_RSH_RET:    r = cap(e.remote_shared_peer_returned, m, 5'h03);
			EVT_LDD_RET_A:  r = cap(e.local_dedicated_peer_returned_a, m, 5'h01);
			EVT_LDD_RET_B:  r = cap(e.local_dedicated_peer_returned_b, m, 5'h01);
			EVT_RDD_RET:    r = cap(e.remote_dedicated_peer_returned, m, 5'h01);
			EVT_LSH_TK_A:   r = cap(e.local_shared_peer_taken_a, m, 5'h01);
			EVT_LSH_TK_B:   r = cap(e.local_shared_peer_taken_b, m, 5'h01);
			EVT_RSH_TK_A:   r = cap(e.remote_shared_peer_taken_a, m, 5'h01);
			EVT_RSH_TK_B:   r = cap(e.remote_shared_peer_taken_b, m, 5'h01);
			EVT_LSH_BACK:   r = cap(e.local_shared_peer_given_back, m, 5'h01);
			EVT_RSH_BACK:   r = cap(e.remote_shared_peer_given_back, m, 5'h03);
			EVT_LDD_TK_A:   r = cap(e.local_dedicated_peer_taken_a, m, 5'h03);
			EVT_LDD_TK_B:   r = cap(e.local_dedicated_peer_taken_b, m, 5'h01);
			EVT_RDD_TK_A:   r = cap(e.remote_dedicated_peer_taken_a, m, 5'h01);
			EVT_RDD_TK_B:   r = cap(e.remote_dedicated_peer_taken_b, m, 5'h01);
			EVT_LSH_WAIT_A: r = cap(e.local_shared_peer_wait_a, m, 5'h01);
			EVT_LSH_WAIT_B: r = cap(e.local_shared_peer_wait_b, m, 5'h01);
			EVT_RSH_WAIT_A: r = cap(e.remote_shared_peer_wait_a, m, 5'h01);
			EVT_RSH_WAIT_B: r = cap(e.remote_shared_peer_wait_b, m, 5'h01);
			EVT_OCC: begin
				// Occupancy can reach 127 but the adder takes five bits, so it saturates.
				if (first && m != 8'h00) begin
					r = (e.peer_credit_occupancy > 7'h1f) ? 5'h1f :
						e.peer_credit_occupancy[4:0];
				end
			end
			default: r = 5'h00;
		endcase
		return r;
	endfunction

	// A ring request reaches the stack only when its class has a free credit.
	assign obtain_w = ring_req_valid & stack_credit_free[ring_req_standard];
	assign refuse_w = ring_req_valid & ~stack_credit_free[ring_req_standard];
	assign stack_fwd_valid = obtain_w;

	// Fold the local credit check into the obtained and refused indications.
	always_comb begin
		ev_w = bridge_events;
		ev_w.stack_credit_obtained[OBT_BYPASS_BIT] =
			bridge_events.stack_credit_obtained[OBT_BYPASS_BIT] | (obtain_w & ~ring_req_standard);
		ev_w.stack_credit_obtained[OBT_STD_BIT] =
			bridge_events.stack_credit_obtained[OBT_STD_BIT] | (obtain_w & ring_req_standard);
		ev_w.stack_credit_refused[REF_BYPASS_BIT] =
			bridge_events.stack_credit_refused[REF_BYPASS_BIT] | (refuse_w & ~ring_req_standard);
		ev_w.stack_credit_refused[REF_STD_BIT] =
			bridge_events.stack_credit_refused[REF_STD_BIT] | (refuse_w & ring_req_standard);
	end

	// Counting runs only when globally enabled and not frozen.
	assign run_w = glob_reg[GLOB_EN_BIT] & ~glob_reg[GLOB_FRZ_BIT];

	// Per-counter increment selection.
	always_comb begin
		for (int i = 0; i < NUM_CTR; i++) begin
			inc_w[i] = sel_inc(ctl_reg[i][CTL_EVT_LSB +: 8], ctl_reg[i][CTL_MASK_LSB +: 8],
				i == 0, i < 2, ev_w);
		end
	end

	// Write channel: address and data are taken independently, in either order.
	assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
	assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
	assign wr_fire       = aw_hold_reg & w_hold_reg & ~bvalid_reg;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			aw_hold_reg <= 1'b0;
			awaddr_reg  <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_reg <= 1'b1;
			awaddr_reg  <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_hold_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			w_hold_reg <= 1'b0;
			wdata_reg  <= 32'h0000_0000;
			wstrb_reg  <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_reg <= 1'b1;
			wdata_reg  <= s_axi_wdata;
			wstrb_reg  <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_hold_reg <= 1'b0;
		end
	end

	// Current word at the write address, merged with the strobed bytes.
	always_comb begin
		wr_ok     = (awaddr_reg == OFS_GLOB);
		wr_old    = {30'h0, glob_reg};
		ctr_lo_wr = '0;
		ctr_hi_wr = '0;
		for (int i = 0; i < NUM_CTR; i++) begin
			if (awaddr_reg == OFS_CTL_BASE + 8'(4 * i)) begin
				wr_ok  = 1'b1;
				wr_old = ctl_reg[i];
			end
			if (awaddr_reg == OFS_CTR_BASE + 8'(8 * i)) begin
				wr_ok  = 1'b1;
				wr_old = ctr_reg[i][31:0];
				ctr_lo_wr[i] = wr_fire;
			end
			if (awaddr_reg == OFS_CTR_BASE + 8'(8 * i + 4)) begin
				wr_ok  = 1'b1;
				wr_old = {16'h0, ctr_reg[i][47:32]};
				ctr_hi_wr[i] = wr_fire;
			end
		end
		for (int b = 0; b < 4; b++) begin
			wr_word[8*b +: 8] = wstrb_reg[b] ? wdata_reg[8*b +: 8] : wr_old[8*b +: 8];
		end
	end

	// Write response; unmapped addresses answer with a slave error.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;

	// Global enable and freeze.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			glob_reg <= GLOB_RST;
		end else if (wr_fire && awaddr_reg == OFS_GLOB) begin
			glob_reg <= wr_word[1:0];
		end
	end

	// Control words: event code, unit mask and local enable.
	always_ff @(posedge clock) begin
		for (int i = 0; i < NUM_CTR; i++) begin
			if (sys_rst) begin
				ctl_reg[i] <= CTL_RST;
			end else if (wr_fire && awaddr_reg == OFS_CTL_BASE + 8'(4 * i)) begin
				ctl_reg[i] <= wr_word;
			end
		end
	end

	// Counters: a software write wins over the increment of that cycle.
	always_ff @(posedge clock) begin
		for (int i = 0; i < NUM_CTR; i++) begin
			if (sys_rst) begin
				ctr_reg[i] <= '0;
			end else if (ctr_lo_wr[i]) begin
				ctr_reg[i][31:0] <= wr_word;
			end else if (ctr_hi_wr[i]) begin
				ctr_reg[i][47:32] <= wr_word[15:0];
			end else if (run_w && ctl_reg[i][CTL_EN_BIT]) begin
				ctr_reg[i] <= ctr_reg[i] + CTR_W'(inc_w[i]);
			end
		end
	end

	// Read decode.
	always_comb begin
		rd_ok   = (s_axi_araddr == OFS_GLOB);
		rd_word = {30'h0, glob_reg};
		for (int i = 0; i < NUM_CTR; i++) begin
			if (s_axi_araddr == OFS_CTL_BASE + 8'(4 * i)) begin
				rd_ok   = 1'b1;
				rd_word = ctl_reg[i];
			end
			if (s_axi_araddr == OFS_CTR_BASE + 8'(8 * i)) begin
				rd_ok   = 1'b1;
				rd_word = ctr_reg[i][31:0];
			end
			if (s_axi_araddr == OFS_CTR_BASE + 8'(8 * i + 4)) begin
				rd_ok   = 1'b1;
				rd_word = {16'h0, ctr_reg[i][47:32]};
			end
		end
	end

	// Read channel answers one cycle after the address is taken.
	assign s_axi_arready = ~rvalid_reg;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_ok ? rd_word : 32'h0000_0000;
			rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

	// Checks on the counting, forwarding and write-response behaviour.
	// Each counting check watches one fixed counter, so it only means something when
	// software places the event of interest on that counter; the counter
	// chosen for each check is the one the usual bring-up sequence uses.
	a_cycle_tick: assert property (@(posedge clock) disable iff (sys_rst)
		(run_w && ctl_reg[2][CTL_EN_BIT] && ctl_reg[2][7:0] == EVT_UNCORE_CYCLE
			&& !ctr_lo_wr[2] && !ctr_hi_wr[2])
		|=> ctr_reg[2] == $past(ctr_reg[2]) + 48'h1)
		else $error("cycle count did not advance by one");
	a_occ_first_only: assert property (@(posedge clock) disable iff (sys_rst)
		(ctl_reg[1][7:0] == EVT_OCC) |-> inc_w[1] == 5'h00)
		else $error("occupancy counted off counter zero");
	a_egress_pair: assert property (@(posedge clock) disable iff (sys_rst)
		(ctl_reg[2][7:0] == EVT_EG_NE) |-> inc_w[2] == 5'h00)
		else $error("egress busy counted off counters zero and one");
	a_frozen_hold: assert property (@(posedge clock) disable iff (sys_rst)
		(!run_w && !ctr_lo_wr[0] && !ctr_hi_wr[0]) |=> $stable(ctr_reg[0]))
		else $error("counter moved while frozen");
	// The wrap check needs a preloaded all-ones counter, which is slow to reach
	// by counting, so it relies on a software preload of the full value.
	a_wrap_zero: assert property (@(posedge clock) disable iff (sys_rst)
		(ctr_reg[1] == {CTR_W{1'b1}} && inc_w[1] == 5'h01 && run_w
			&& ctl_reg[1][CTL_EN_BIT] && !ctr_lo_wr[1] && !ctr_hi_wr[1])
		|=> ctr_reg[1] == '0)
		else $error("counter did not wrap to zero");
	a_single_cap: assert property (@(posedge clock) disable iff (sys_rst)
		(ctl_reg[2][7:0] == EVT_LDD_TK_B) |-> inc_w[2] <= 5'h01)
		else $error("single-step event added more than one");
	a_triple_cap: assert property (@(posedge clock) disable iff (sys_rst)
		(ctl_reg[1][7:0] == EVT_LDD_TK_A) |-> inc_w[1] <= 5'h03)
		else $error("triple-step event added more than three");
	a_fwd_credit: assert property (@(posedge clock) disable iff (sys_rst)
		stack_fwd_valid |-> stack_credit_free[ring_req_standard])
		else $error("forwarded without a credit");
	a_write_resp: assert property (@(posedge clock) disable iff (sys_rst)
		wr_fire |=> s_axi_bvalid ##0 (s_axi_bresp == (
			$past(wr_ok) ? RESP_OKAY : RESP_SLVERR)))
		else $error("write response wrong or late");
endmodule
`default_nettype wire

/* File: verification/mibec_bridge_model.sv */
// Purpose: Far-side model that replays bridge event levels into the counter unit.
// Assumes: The bench hands in a pattern and a run flag on the rising edge.
// Notes:   Quiet cycles drive every event level low, as an idle bridge does.
`default_nettype none
module mibec_bridge_model
	import mibec_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic         run,
	input  wire mibec_event_s pattern,
	output var  mibec_event_s bridge_events,
	output var  int           sent_cycles
);
	timeunit 1ns;
	timeprecision 1ns;
	// Registered replay, so a pattern reaches the unit one cycle after run rises.
	always_ff @(posedge clock) begin
		if (sys_rst || !run) begin
			bridge_events <= '0;
		end else begin
			bridge_events <= pattern;
		end
	end
	// Cycles of live pattern; the bench scales its expected counts by this.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sent_cycles <= 0;
		end else if (run) begin
			sent_cycles <= sent_cycles + 1;
		end
	end
endmodule
`default_nettype wire

/* File: verification/tb_mesh_io_bridge_event_counters.sv */
// Purpose: Self-checking bench for the bridge event counter unit.
// Assumes: One 20 MHz clock and a synchronous active-high reset.
// Notes:   Each table entry is counter, code, unit mask, event value, increment.
`default_nettype none
module tb_mesh_io_bridge_event_counters
	import mibec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int RUN_LEN = 10;
	// Flags in the top nibble: bit 35 drives a starved ring request, bit 34 leaves the counter disabled.
	localparam logic [35:0] case_tab [29] = '{
		36'h0_10_ff_01_01, 36'h1_11_ff_01_01,
		36'h0_23_ff_01_01, 36'h2_23_ff_01_00, 36'h3_24_ff_01_01,
		36'h2_25_ff_01_01, 36'h1_32_03_03_01, 36'h7_10_ff_01_00,
		36'h3_33_01_03_01, 36'h0_34_20_10_00, 36'h8_34_10_00_01,
		36'h1_46_ff_0f_03, 36'h2_47_ff_03_01, 36'h3_19_02_02_01,
		36'h0_40_ff_01_01, 36'h1_41_ff_01_01, 36'h2_42_ff_01_01, 36'h3_43_ff_01_01,
		36'h0_44_ff_07_01, 36'h1_45_ff_07_03, 36'h2_17_ff_07_03, 36'h3_18_ff_03_02,
		36'h0_4a_ff_01_01, 36'h1_4b_ff_01_01, 36'h2_4c_ff_01_01, 36'h3_4d_ff_01_01,
		36'h0_14_01_14_14, 36'h0_14_01_7f_1f, 36'h1_14_01_7f_00
	};
	logic         clock = 1'b0;
	logic         sys_rst = 1'b1;
	logic         run = 1'b0;
	mibec_event_s pattern = '0;
	mibec_event_s bridge_events;
	int           sent_cycles;
	int           cyc = 0;
	int           fails = 0;
	int           samples_checked = 0;
	logic         ring_req_valid = 1'b0;
	logic         ring_req_standard = 1'b0;
	logic [1:0]   stack_credit_free = 2'h3;
	logic         stack_fwd_valid;
	logic [7:0]   s_axi_awaddr = 8'h00;
	logic         s_axi_awvalid = 1'b0;
	logic         s_axi_awready;
	logic [31:0]  s_axi_wdata = 32'h0;
	logic [3:0]   s_axi_wstrb = 4'hf;
	logic         s_axi_wvalid = 1'b0;
	logic         s_axi_wready;
	logic [1:0]   s_axi_bresp;
	logic         s_axi_bvalid;
	logic         s_axi_bready = 1'b0;
	logic [7:0]   s_axi_araddr = 8'h00;
	logic         s_axi_arvalid = 1'b0;
	logic         s_axi_arready;
	logic [31:0]  s_axi_rdata;
	logic [1:0]   s_axi_rresp;
	logic         s_axi_rvalid;
	logic         s_axi_rready = 1'b0;
	logic [31:0]  rdat;
	logic [1:0]   resp;
	// Clock and a free cycle count used to time the clock-tick event.
	always #25 clock = ~clock;
	always @(posedge clock) cyc <= cyc + 1;
	mibec_counters u_dut (.clock, .sys_rst, .bridge_events, .ring_req_valid, .ring_req_standard,
		.stack_credit_free, .stack_fwd_valid, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	mibec_bridge_model u_model (.clock, .sys_rst, .run, .pattern, .bridge_events, .sent_cycles);
	// Comparison, verdict and hang handling.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d fails=%0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Each channel drops its valid once taken; the answer is awaited with a bound.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
			end
		end while (!s_axi_bvalid && n < 50);
		if (!s_axi_bvalid) begin
			fails++;
			final_report();
		end
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
			end
		end while (!s_axi_rvalid && n < 50);
		if (!s_axi_rvalid) begin
			fails++;
			final_report();
		end
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clock);
	endtask
	// A starved ring request has no credit of either class while it runs.
	task automatic run_events(input mibec_event_s p, input logic ring, input int n);
		pattern <= p;
		run <= 1'b1;
		ring_req_valid <= ring;
		ring_req_standard <= 1'b0;
		stack_credit_free <= ring ? 2'h0 : 2'h3;
		repeat (n) @(posedge clock);
		run <= 1'b0;
		ring_req_valid <= 1'b0;
		stack_credit_free <= 2'h3;
		repeat (3) @(posedge clock);
	endtask
	// Places an event value in the field that the given code watches.
	function automatic mibec_event_s make_pat(input logic [7:0] code, input logic [7:0] v);
		mibec_event_s p;
		p = '0;
		case (code)
			EVT_IN_NE: p.ingress_not_empty_cycles = v[0];
			EVT_IN_INS: p.ingress_insertions = v[0];
			EVT_EG_NE: p.egress_not_empty_cycles = v[0];
			EVT_EG_INS: p.egress_insertions = v[0];
			EVT_EG_FULL: p.egress_full_cycles = v[0];
			EVT_HELD: p.stack_credit_held_cycles = v;
			EVT_OBT: p.stack_credit_obtained = v;
			EVT_REF: p.stack_credit_refused = v;
			EVT_OCC: p.peer_credit_occupancy = v[6:0];
			EVT_LSH_RET: p.local_shared_peer_returned = v;
			EVT_RSH_RET: p.remote_shared_peer_returned = v;
			EVT_LDD_RET_A: p.local_dedicated_peer_returned_a = v;
			EVT_LSH_TK_A: p.local_shared_peer_taken_a = v;
			EVT_LSH_TK_B: p.local_shared_peer_taken_b = v;
			EVT_RSH_TK_A: p.remote_shared_peer_taken_a = v;
			EVT_RSH_TK_B: p.remote_shared_peer_taken_b = v;
			EVT_LSH_BACK: p.local_shared_peer_given_back = v;
			EVT_RSH_BACK: p.remote_shared_peer_given_back = v;
			EVT_LDD_TK_A: p.local_dedicated_peer_taken_a = v;
			EVT_LDD_TK_B: p.local_dedicated_peer_taken_b = v;
			EVT_LSH_WAIT_A: p.local_shared_peer_wait_a = v;
			EVT_LSH_WAIT_B: p.local_shared_peer_wait_b = v;
			EVT_RSH_WAIT_A: p.remote_shared_peer_wait_a = v;
			EVT_RSH_WAIT_B: p.remote_shared_peer_wait_b = v;
			default: p = '0;
		endcase
		return p;
	endfunction
	// Main sequence: reset values, forwarding, event table, wrap, clock ticks.
	initial begin
		logic [35:0] e;
		logic [7:0]  lo;
		int          s0;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		rd(OFS_CTL_BASE);
		check(rdat, CTL_RST);
		rd(8'hfc);
		check({rdat[29:0], resp}, {30'h0, RESP_SLVERR});
		wr(8'hfc, 32'h1);
		check({30'h0, resp}, {30'h0, RESP_SLVERR});
		for (int i = 0; i < 16; i++) begin
			ring_req_valid <= i[0];
			ring_req_standard <= i[1];
			stack_credit_free <= i[3:2];
			@(posedge clock);
			check({31'h0, stack_fwd_valid}, {31'h0, i[0] && i[2 + i[1]]});
		end
		run_events('0, 1'b0, 1);
		foreach (case_tab[i]) begin
			e = case_tab[i];
			lo = OFS_CTR_BASE + {3'h0, e[33:32], 3'h0};
			wr(OFS_CTL_BASE + {4'h0, e[33:32], 2'h0}, {9'h0, !e[34], 6'h0, e[23:16], e[31:24]});
			wr(lo, 32'h0);
			wr(lo + 8'h04, 32'h0);
			wr(OFS_GLOB, 32'h1);
			s0 = sent_cycles;
			run_events(make_pat(e[31:24], e[15:8]), e[35], RUN_LEN);
			wr(OFS_GLOB, 32'h0);
			rd(lo);
			check(rdat, 32'(sent_cycles - s0) * {24'h0, e[7:0]});
		end
		wr(OFS_CTL_BASE + 8'h04, 32'h0040_0010);
		wr(OFS_CTR_BASE + 8'h08, 32'hffff_ffff);
		wr(OFS_CTR_BASE + 8'h0c, 32'h0000_ffff);
		wr(OFS_GLOB, 32'h1);
		run_events(make_pat(EVT_IN_NE, 8'h01), 1'b0, 2);
		wr(OFS_GLOB, 32'h0);
		rd(OFS_CTR_BASE + 8'h08);
		check(rdat, 32'h1);
		rd(OFS_CTR_BASE + 8'h0c);
		check(rdat, 32'h0);
		wr(OFS_CTL_BASE + 8'h08, 32'h0040_0001);
		wr(OFS_CTR_BASE + 8'h10, 32'h0);
		wr(OFS_GLOB, 32'h1);
		s0 = cyc;
		repeat (20) @(posedge clock);
		wr(OFS_GLOB, 32'h3);
		s0 = cyc - s0;
		repeat (10) @(posedge clock);
		rd(OFS_CTR_BASE + 8'h10);
		check({31'h0, (rdat - 32'(s0) + 32'h1) <= 32'h2}, 32'h1);
		final_report();
	end
endmodule
`default_nettype wire
